// file: ep_cfg_core.sv
// Endpoint configuration, buffer allocation and payload access logic
//
// Behaviour
// - Endpoints use up to one (endpoint 0), two (endpoints 1-2) or three (endpoints 3-6) payload banks as configured.
// - Processor and USB side keep separate bank pointers; on single-bank endpoints both use the one bank.
// - Shared payload RAM holds 4 KB split among active endpoints.
// - Suspend and resume are detected by hardware and flagged.
// - Control endpoints use one bank; stall aborts a control transfer.
// - Endpoint 0 is always a control endpoint.
// - Direction is ignored on control endpoints.
// - Mapped flag set only when size and banks fit allowed limits.
// - Mapped flag clear when demand of the endpoint and all lower endpoints exceeds RAM capacity.
// - Endpoints 1 to 6 may be bulk, interrupt or isochronous.
// - Packets up to the configured endpoint size are accepted.
// - Endpoint block repeats across a 64 KB processor window.
// - Auto validation validates full banks and moves to next bank.
// - Transmit bank ready flag raised after each IN packet.
// - Receive bank ready flag raised after each stored OUT packet.
// - Status stage handled as data stage of same direction.
module ep_cfg_core
    import ep_cfg_pkg::*;
#(
    parameter int SUSP_CNT = SUSP_CYCLES  // Idle cycles before suspend
) (
    input  wire logic               clk_sys,      // System clock, 40 MHz
    input  wire logic               arst_n,       // Async reset, active low
    input  wire logic [7:0]         reg_addr,     // Register word address
    input  wire logic [31:0]        reg_wdata,    // Register write data
    input  wire logic               reg_wr,       // Register write strobe
    input  wire logic               reg_rd,       // Register read strobe
    output logic      [31:0]        reg_rdata,    // Register read data
    input  wire logic [2:0]         win_ep,       // Window endpoint select
    input  wire logic [WIN_AW-1:0]  win_addr,     // Word address in window
    input  wire logic [31:0]        win_wdata,    // Window write data
    input  wire logic               win_wr,       // Window write strobe
    input  wire logic               win_rd,       // Window read strobe
    output logic      [31:0]        win_rdata,    // Window read data
    input  wire logic [2:0]         usb_ep,       // USB side endpoint
    input  wire logic [7:0]         usb_word,     // Word within packet
    input  wire logic [31:0]        usb_wdata,    // USB side write data
    input  wire logic               usb_wr,       // USB side write strobe
    input  wire logic               usb_done,     // Packet finished pulse
    output logic      [31:0]        usb_rdata,    // USB side read data
    output logic      [NUM_EP-1:0]  stall_ff,     // Stall handshake request
    input  wire logic               bus_idle,     // Line idle level
    input  wire logic               bus_reset_end // End of bus reset pulse
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [9:0]       cfg_ff   [NUM_EP];
    logic [4:0]       ctl_ff   [NUM_EP];
    logic [1:0]       cpu_bk_ff[NUM_EP];
    logic [1:0]       usb_bk_ff[NUM_EP];
    logic [NUM_EP-1:0] txrdy_ff;
    logic [NUM_EP-1:0] rxrdy_ff;
    logic [NUM_EP-1:0] mapd;
    logic [12:0]      bsz      [NUM_EP];
    logic [1:0]       nbk      [NUM_EP];
    logic [14:0]      base     [NUM_EP+1];  // Wide enough for the worst total demand
    logic [2:0]       evt_ff;
    link_state_t      link_ff;
    logic [17:0]      idle_cnt_ff;
    logic             rd_win_ff;

    // ------------------------------------------------------------------
    // Per-endpoint decode and allocation
    // ------------------------------------------------------------------
    assign base[0] = 15'h0000;
    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
        xfer_type_t ty;
        logic [1:0] req_bk;
        logic [1:0] max_bk;
        logic [2:0] sz_code;
        assign sz_code = cfg_ff[e][CFG_SIZE_LSB +: 3];
        // Endpoint 0 and control endpoints forced to one bank
        assign ty     = (e == 0) ? TYPE_CTRL
                                 : xfer_type_t'(cfg_ff[e][CFG_TYPE_LSB +: 2]);
        assign req_bk = cfg_ff[e][CFG_BANK_LSB +: 2];
        assign max_bk = (e == 0) ? 2'h1 : ((e < 3) ? 2'h2 : 2'h3);
        assign nbk[e] = (ty == TYPE_CTRL) ? 2'h1 : req_bk;
        // Size is 8 shifted by the code; endpoint 0 is fixed
        assign bsz[e] = (e == 0) ? EP0_FIXED_SZ
                                 : 13'(13'h0008 << sz_code);
        // Regions packed in endpoint order
        assign base[e+1] = 15'(base[e] + 15'(bsz[e]) * 15'(nbk[e]));
        // Fit checks: bank limits and cumulative capacity
        assign mapd[e] = (req_bk != 2'h0) && (nbk[e] <= max_bk)
                       && (sz_code <= 3'h7) && (base[e+1] <= 15'(RAM_CAP))
                       && !((ty == TYPE_CTRL) && (req_bk != 2'h1));
    end

    // ------------------------------------------------------------------
    // Configuration and control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int e = 0; e < NUM_EP; e++) begin
                cfg_ff[e] <= CFG_RST;
                ctl_ff[e] <= CTL_RST;
            end
        end else if (reg_wr) begin
            for (int e = 0; e < NUM_EP; e++) begin
                if (reg_addr == CFG_BASE + 8'(e)) begin
                    cfg_ff[e] <= reg_wdata[9:0];
                end
                if (reg_addr == CTL_BASE + 8'(e)) begin
                    ctl_ff[e] <= reg_wdata[4:0];
                end
            end
        end
    end

    // Stall output follows the stall bit, gated by the enable bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stall_ff <= '0;
        end else begin
            for (int e = 0; e < NUM_EP; e++) begin
                stall_ff[e] <= ctl_ff[e][CTL_STALL_BIT] && ctl_ff[e][CTL_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Bank pointers and bank ready flags
    // ------------------------------------------------------------------
    logic [NUM_EP-1:0] cpu_last;
    logic [NUM_EP-1:0] win_hit;
    for (genvar e = 0; e < NUM_EP; e++) begin : g_bk
        logic [12:0] off;
        assign off         = 13'({win_addr, 2'b00} % bsz[e]);
        assign win_hit[e]  = win_wr && (win_ep == 3'(e));
        assign cpu_last[e] = win_hit[e] && (off == bsz[e] - 13'h0004);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int e = 0; e < NUM_EP; e++) begin
                cpu_bk_ff[e] <= 2'h0;
                usb_bk_ff[e] <= 2'h0;
            end
        end else begin
            for (int e = 0; e < NUM_EP; e++) begin
                // Processor moves on after filling a bank in auto mode
                if (cpu_last[e] && ctl_ff[e][CTL_AUTO_BIT]) begin
                    cpu_bk_ff[e] <= (cpu_bk_ff[e] + 2'h1 >= nbk[e]) ? 2'h0
                                                                 : 2'(cpu_bk_ff[e] + 2'h1);
                end
                // USB side moves to the next bank per packet
                if (usb_done && usb_ep == 3'(e)) begin
                    usb_bk_ff[e] <= (usb_bk_ff[e] + 2'h1 >= nbk[e]) ? 2'h0
                                                                 : 2'(usb_bk_ff[e] + 2'h1);
                end
            end
        end
    end

    // Sticky ready flags, set wins over status read clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            txrdy_ff <= '0;
            rxrdy_ff <= '0;
        end else begin
            for (int e = 0; e < NUM_EP; e++) begin
                logic dir_in;
                logic done;
                dir_in = cfg_ff[e][CFG_DIR_BIT] && (nbk[e] != 2'h0)
                       && (e != 0) && (cfg_ff[e][CFG_TYPE_LSB +: 2] != TYPE_CTRL);
                done   = usb_done && (usb_ep == 3'(e)) && ctl_ff[e][CTL_EN_BIT];
                if (reg_rd && reg_addr == STA_BASE + 8'(e)) begin
                    txrdy_ff[e] <= 1'b0;
                    rxrdy_ff[e] <= 1'b0;
                end
                if (done && dir_in && ctl_ff[e][CTL_TXI_BIT]) begin
                    txrdy_ff[e] <= 1'b1;
                end
                if (done && !dir_in && ctl_ff[e][CTL_RXI_BIT]) begin
                    rxrdy_ff[e] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Suspend and resume detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt_ff <= '0;
            link_ff     <= LINK_ACTIVE;
        end else begin
            idle_cnt_ff <= bus_idle ? ((idle_cnt_ff == 18'(SUSP_CNT)) ? idle_cnt_ff
                                                      : 18'(idle_cnt_ff + 18'h1)) : '0;
            case (link_ff)
                LINK_ACTIVE: begin
                    if (idle_cnt_ff == 18'(SUSP_CNT - 1)) begin
                        link_ff <= LINK_SUSPEND;
                    end
                end
                LINK_SUSPEND: begin
                    if (!bus_idle) begin
                        link_ff <= LINK_ACTIVE;
                    end
                end
                default: link_ff <= LINK_ACTIVE;
            endcase
        end
    end

    // Event flags: clear on read, new event wins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            evt_ff <= '0;
        end else begin
            if (reg_rd && reg_addr == EVT_ADDR) begin
                evt_ff <= '0;
            end
            if (link_ff == LINK_ACTIVE && idle_cnt_ff == 18'(SUSP_CNT - 1)) begin
                evt_ff[EVT_SUSP_BIT] <= 1'b1;
            end
            if (link_ff == LINK_SUSPEND && !bus_idle) begin
                evt_ff[EVT_RES_BIT] <= 1'b1;
            end
            if (bus_reset_end) begin
                evt_ff[EVT_EOR_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Payload RAM addressing and window remap
    // ------------------------------------------------------------------
    logic [12:0] cpu_byte;
    logic [12:0] usb_byte;
    always_comb begin
        cpu_byte = 13'(base[win_ep] + bsz[win_ep] * 13'(cpu_bk_ff[win_ep])
                 + 13'({win_addr, 2'b00} % bsz[win_ep]));
        usb_byte = 13'(base[usb_ep] + bsz[usb_ep] * 13'(usb_bk_ff[usb_ep])
                 + 13'({usb_word, 2'b00} % bsz[usb_ep]));
    end

    logic [31:0] ram_a_rdata;
    ep_payload_ram u_ram (
        .clk_sys (clk_sys),
        .a_we    (win_wr && win_ep < 3'(NUM_EP) && mapd[win_ep]),
        .a_addr  (cpu_byte[11:2]),
        .a_wdata (win_wdata),
        .a_rdata (ram_a_rdata),
        .b_we    (usb_wr && usb_ep < 3'(NUM_EP) && mapd[usb_ep]),
        .b_addr  (usb_byte[11:2]),
        .b_wdata (usb_wdata),
        .b_rdata (usb_rdata)
    );

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_win_ff <= 1'b0;
        end else begin
            rd_win_ff <= win_rd;
        end
    end
    assign win_rdata = rd_win_ff ? ram_a_rdata : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            for (int e = 0; e < NUM_EP; e++) begin
                if (reg_addr == CFG_BASE + 8'(e)) begin
                    reg_rdata <= {mapd[e], 21'h0, cfg_ff[e]};
                end
                if (reg_addr == CTL_BASE + 8'(e)) begin
                    reg_rdata <= {27'h0, ctl_ff[e]};
                end
                if (reg_addr == STA_BASE + 8'(e)) begin
                    reg_rdata <= {24'h0, usb_bk_ff[e], cpu_bk_ff[e],
                                  2'h0, rxrdy_ff[e], txrdy_ff[e]};
                end
            end
            if (reg_addr == EVT_ADDR) begin
                reg_rdata <= {29'h0, evt_ff};
            end
            if (reg_addr == BUS_ADDR) begin
                reg_rdata <= {31'h0, link_ff == LINK_SUSPEND};
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_ep0_one_bank: assert property (@(posedge clk_sys) disable iff (!arst_n)
        nbk[0] == 2'h1) else $error("ep0 not single bank");
    chk_map_capacity: assert property (@(posedge clk_sys) disable iff (!arst_n)
        mapd[NUM_EP-1] |-> base[NUM_EP] <= 15'(RAM_CAP)) else $error("map over cap");
    chk_suspend_evt: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(link_ff == LINK_SUSPEND) |-> evt_ff[EVT_SUSP_BIT])
        else $error("suspend not flagged");
    chk_resume_evt: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(link_ff == LINK_SUSPEND) |-> evt_ff[EVT_RES_BIT])
        else $error("resume not flagged");
    chk_read_latency: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !win_rd |=> win_rdata == 32'h0) else $error("window data stray");
    // Finished OUT packet with receive flag enabled must raise the flag
    for (genvar e = 0; e < NUM_EP; e++) begin : g_chk
        chk_rx_ready_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
            usb_done && usb_ep == 3'(e) && ctl_ff[e][CTL_EN_BIT] && ctl_ff[e][CTL_RXI_BIT]
            && !cfg_ff[e][CFG_DIR_BIT] |=> rxrdy_ff[e]) else $error("rx ready not set");
    end

endmodule : ep_cfg_core

// file: ep_cfg_pkg.sv
// Package: constants and types for the endpoint configuration block
package ep_cfg_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int          NUM_EP        = 7;
    localparam int          RAM_BYTES     = 4096;
    localparam int          RAM_WORDS     = RAM_BYTES / 4;
    localparam int          RAM_AW        = 10;
    localparam int          WIN_AW        = 14;
    localparam logic [12:0] RAM_CAP       = 13'h1000;
    localparam logic [12:0] EP0_FIXED_SZ  = 13'h0040;

    // ------------------------------------------------------------------
    // Register map (word addresses, byte address is four times this)
    // ------------------------------------------------------------------
    localparam logic [7:0]  CFG_BASE      = 8'h00;
    localparam logic [7:0]  CTL_BASE      = 8'h08;
    localparam logic [7:0]  STA_BASE      = 8'h10;
    localparam logic [7:0]  EVT_ADDR      = 8'h18;
    localparam logic [7:0]  BUS_ADDR      = 8'h19;

    // ------------------------------------------------------------------
    // Configuration register fields
    // ------------------------------------------------------------------
    localparam int          CFG_SIZE_LSB  = 0;
    localparam int          CFG_DIR_BIT   = 3;
    localparam int          CFG_TYPE_LSB  = 4;
    localparam int          CFG_BANK_LSB  = 6;
    localparam int          CFG_NTR_LSB   = 8;
    localparam int          CFG_MAPD_BIT  = 31;
    localparam logic [9:0]  CFG_RST       = 10'h000;

    // Control register fields
    localparam int          CTL_EN_BIT    = 0;
    localparam int          CTL_AUTO_BIT  = 1;
    localparam int          CTL_TXI_BIT   = 2;
    localparam int          CTL_RXI_BIT   = 3;
    localparam int          CTL_STALL_BIT = 4;
    localparam logic [4:0]  CTL_RST       = 5'h00;

    // Event register bits
    localparam int          EVT_SUSP_BIT  = 0;
    localparam int          EVT_RES_BIT   = 1;
    localparam int          EVT_EOR_BIT   = 2;

    // Idle cycles before suspend: 3 ms at 40 MHz
    localparam int          SUSP_TIME_US  = 3000;
    localparam int          CLK_MHZ       = 40;
    localparam int          SUSP_CYCLES   = SUSP_TIME_US * CLK_MHZ;

    // Transfer type codes
    typedef enum logic [1:0] {
        TYPE_CTRL = 2'h0,
        TYPE_ISO  = 2'h1,
        TYPE_BULK = 2'h2,
        TYPE_INT  = 2'h3
    } xfer_type_t;

    // Link power state, one-hot
    typedef enum logic [1:0] {
        LINK_ACTIVE  = 2'b01,
        LINK_SUSPEND = 2'b10
    } link_state_t;

endpackage : ep_cfg_pkg

// file: ep_payload_ram.sv
// Dual-port payload memory with registered read data on both ports
module ep_payload_ram
    import ep_cfg_pkg::*;
#(
    parameter int WORDS = RAM_WORDS,
    parameter int AW    = RAM_AW
) (
    input  wire logic          clk_sys,   // System clock
    input  wire logic          a_we,      // Processor write
    input  wire logic [AW-1:0] a_addr,    // Processor address
    input  wire logic [31:0]   a_wdata,   // Processor write data
    output logic      [31:0]   a_rdata,   // Processor read data
    input  wire logic          b_we,      // USB side write
    input  wire logic [AW-1:0] b_addr,    // USB side address
    input  wire logic [31:0]   b_wdata,   // USB side write data
    output logic      [31:0]   b_rdata    // USB side read data
);

    logic [31:0] mem [WORDS];

    // ------------------------------------------------------------------
    // Two independent ports
    // ------------------------------------------------------------------
    // One process owns the array; USB side wins a same-word clash
    always_ff @(posedge clk_sys) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end

endmodule : ep_payload_ram

// file: host_model.sv
// Behavioural host controller that drives the packet side of the endpoint block
module host_model
    import ep_cfg_pkg::*;
(
    input  wire logic        clk_sys,       // System clock
    output logic [2:0]       usb_ep,        // Endpoint addressed
    output logic [7:0]       usb_word,      // Word within packet
    output logic [31:0]      usb_wdata,     // Packet data
    output logic             usb_wr,        // Word write strobe
    output logic             usb_done,      // Packet end pulse
    input  wire logic [31:0] usb_rdata,     // Data read back
    output logic             bus_idle,      // Line idle level
    output logic             bus_reset_end  // End of bus reset pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet lines at start, bus kept busy so no suspend is seen
    initial begin
        usb_ep = 3'h0;
        usb_word = 8'h00;
        usb_wdata = 32'h0;
        usb_wr = 1'b0;
        usb_done = 1'b0;
        bus_idle = 1'b0;
        bus_reset_end = 1'b0;
    end

    // Store one packet word; released data turns to its inverse
    task automatic put(input logic [2:0] ep, input logic [7:0] w, input logic [31:0] d);
        @(posedge clk_sys);
        usb_ep <= ep;
        usb_word <= w;
        usb_wdata <= d;
        usb_wr <= 1'b1;
        @(posedge clk_sys);
        usb_wr <= 1'b0;
        usb_wdata <= ~d;
    endtask : put

    // Close a packet on one endpoint
    task automatic done(input logic [2:0] ep);
        @(posedge clk_sys);
        usb_ep <= ep;
        usb_done <= 1'b1;
        @(posedge clk_sys);
        usb_done <= 1'b0;
    endtask : done

    // Fetch one word, data stands one cycle after the address
    task automatic get(input logic [2:0] ep, input logic [7:0] w, output logic [31:0] d);
        @(posedge clk_sys);
        usb_ep <= ep;
        usb_word <= w;
        @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        d = usb_rdata;
    endtask : get

    // Signal the end of a bus reset
    task automatic reset_end();
        @(posedge clk_sys);
        bus_reset_end <= 1'b1;
        @(posedge clk_sys);
        bus_reset_end <= 1'b0;
    endtask : reset_end

    // Hold the line idle or busy from the next edge on
    task automatic set_idle(input logic v);
        @(posedge clk_sys);
        bus_idle <= v;
    endtask : set_idle
endmodule : host_model

// file: testbench.sv
// Self-checking bench: register, window and packet paths of the endpoint block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ep_cfg_pkg::*;

    typedef struct {bit w; logic [31:0] e; logic [31:0] m;} note_t;

    // ------------------------------------------------------------------
    // Stimulus signals
    // ------------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, win_rdata, usb_rdata, usb_wdata;
    logic [2:0] win_ep = 3'h0;
    logic [WIN_AW-1:0] win_addr = '0;
    logic [31:0] win_wdata = 32'h0;
    logic win_wr = 1'b0;
    logic win_rd = 1'b0;
    logic [2:0] usb_ep;
    logic [7:0] usb_word;
    logic usb_wr, usb_done, bus_idle, bus_reset_end;
    logic [NUM_EP-1:0] stall_ff;
    int err_total = 0;
    int total_checks = 0;
    note_t nq[$];
    note_t n;
    bit pend = 1'b0;
    logic [31:0] lfsr = 32'h7eb6;

    always #12.5 clk_sys = ~clk_sys;

    ep_cfg_core #(.SUSP_CNT(40)) ep_cfg_core_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .win_ep(win_ep), .win_addr(win_addr), .win_wdata(win_wdata), .win_wr(win_wr),
        .win_rd(win_rd), .win_rdata(win_rdata), .usb_ep(usb_ep), .usb_word(usb_word),
        .usb_wdata(usb_wdata), .usb_wr(usb_wr), .usb_done(usb_done), .usb_rdata(usb_rdata),
        .stall_ff(stall_ff), .bus_idle(bus_idle), .bus_reset_end(bus_reset_end));

    host_model host_model_inst (.clk_sys(clk_sys), .usb_ep(usb_ep), .usb_word(usb_word),
        .usb_wdata(usb_wdata), .usb_wr(usb_wr), .usb_done(usb_done), .usb_rdata(usb_rdata),
        .bus_idle(bus_idle), .bus_reset_end(bus_reset_end));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt_rand

    // One register or window cycle; a read leaves a note for the watcher
    task automatic rw(input bit win, input bit rd, input logic [2:0] ep,
                      input logic [13:0] a, input logic [31:0] d, input logic [31:0] m);
        if (rd) nq.push_back('{win, d, m});
        if (win) begin
            win_ep <= ep;
            win_addr <= a;
            win_wdata <= d;
            win_wr <= !rd;
            win_rd <= rd;
        end else begin
            reg_addr <= a[7:0];
            reg_wdata <= d;
            reg_wr <= !rd;
            reg_rd <= rd;
        end
        @(posedge clk_sys);
        {win_wr, win_rd, reg_wr, reg_rd} <= 4'h0;
        @(posedge clk_sys);
    endtask : rw

    // Read data stands in the cycle after the strobe: compare with oldest note
    always @(posedge clk_sys) begin
        #1;
        if (pend) begin
            n = nq.pop_front();
            check((n.w ? win_rdata : reg_rdata) & n.m, n.e & n.m);
        end
        pend = reg_rd | win_rd;
    end

    // Watchdog
    initial begin
        #(25 * 5000);
        err_total++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [9:0] cfg [6] = '{10'h043, 10'h0e8, 10'h197, 10'h0ee, 10'h0b6, 10'h088};
        logic [5:0] mapd = 6'b001101;
        logic [31:0] r [4];
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt_rand(lfsr);
            r[i] = lfsr;
        end
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // Configure endpoints 0 to 5, then read back the mapped flags
        for (int i = 0; i < 6; i++) rw(0, 0, 0, 14'(CFG_BASE + 8'(i)), 32'(cfg[i]), '1);
        for (int i = 0; i < 6; i++) rw(0, 1, 0, 14'(CFG_BASE + 8'(i)), {mapd[i], 21'h0, cfg[i]}, '1);
        rw(0, 0, 0, 14'(CTL_BASE), 32'h11, '1);
        rw(0, 0, 0, 14'(CTL_BASE + 8'h2), 32'h09, '1);
        rw(0, 0, 0, 14'(CTL_BASE + 8'h3), 32'h05, '1);
        repeat (2) @(posedge clk_sys);
        #1;
        check({25'h0, stall_ff}, 32'h1);
        @(posedge clk_sys);
        rw(0, 1, 0, 14'(CTL_BASE), 32'h11, 32'h1f);
        rw(0, 0, 0, 14'(CTL_BASE), 32'h01, '1);
        repeat (2) @(posedge clk_sys);
        #1;
        check({25'h0, stall_ff}, 32'h0);
        @(posedge clk_sys);
        // Window aliasing and separation of endpoint blocks
        rw(1, 0, 3, 14'h0005, r[0], '1);
        rw(1, 0, 2, 14'h0005, r[1], '1);
        rw(1, 1, 3, 14'h0485, r[0], '1);
        rw(1, 1, 3, 14'h0005, r[0], '1);
        rw(1, 1, 2, 14'h0005, r[1], '1);
        // Single-bank endpoint shared by both sides
        rw(1, 0, 0, 14'h0002, r[2], '1);
        host_model_inst.get(3'h0, 8'h02, d);
        check(d, r[2]);
        @(posedge clk_sys);
        host_model_inst.put(3'h0, 8'h03, r[3]);
        rw(1, 1, 0, 14'h0003, r[3], '1);
        // Bank ready flags, cleared by reading
        host_model_inst.put(3'h2, 8'h00, r[0]);
        host_model_inst.done(3'h2);
        rw(0, 1, 0, 14'(STA_BASE + 8'h2), 32'h2, 32'h3);
        rw(0, 1, 0, 14'(STA_BASE + 8'h2), 32'h0, 32'h3);
        host_model_inst.done(3'h3);
        rw(0, 1, 0, 14'(STA_BASE + 8'h3), 32'h1, 32'h3);
        // End of bus reset event, cleared by reading
        host_model_inst.reset_end();
        rw(0, 1, 0, 14'(EVT_ADDR), 32'h4, 32'h4);
        rw(0, 1, 0, 14'(EVT_ADDR), 32'h0, 32'h4);
        // Suspend after the idle span, resume when the line wakes
        host_model_inst.set_idle(1'b1);
        repeat (50) @(posedge clk_sys);
        rw(0, 1, 0, 14'(BUS_ADDR), 32'h1, 32'h1);
        host_model_inst.set_idle(1'b0);
        @(posedge clk_sys);
        rw(0, 1, 0, 14'(EVT_ADDR), 32'h3, 32'h3);
        rw(0, 1, 0, 14'(EVT_ADDR), 32'h0, 32'h3);
        // Auto validation: last word of a bank moves the processor bank
        rw(0, 0, 0, 14'(CTL_BASE + 8'h3), 32'h07, '1);
        rw(1, 0, 3, 14'h007f, r[1], '1);
        rw(0, 1, 0, 14'(STA_BASE + 8'h3), 32'h10, 32'h30);
        // Oversized demand must not wrap into a false fit
        rw(0, 0, 0, 14'(CFG_BASE + 8'h4), 32'h1d7, '1);
        rw(0, 0, 0, 14'(CFG_BASE + 8'h5), 32'h1d7, '1);
        rw(0, 1, 0, 14'(CFG_BASE + 8'h5), 32'h1d7, '1);
        rw(0, 1, 0, 14'h0030, 32'h0, '1);
        repeat (3) @(posedge clk_sys);
        print_verdict();
    end
endmodule : testbench
